// File: hdl/bsbm_exec.sv
// Execution unit for branches, system control and block byte moves
`default_nettype none

module bsbm_exec
  import bsbm_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Instruction issue
  input wire logic instValid,
  input wire bsbm_op_t instOp,
  input wire logic [3:0] instCond,
  input wire logic [7:0] instDisp,
  input wire logic [15:0] instTarget,
  input wire logic [7:0] instImm,
  input wire logic [7:0] instRegData,
  output logic instReady,
  output logic instDone,
  // Exception entry and wake-up
  input wire logic excEnter,
  input wire logic [15:0] excVector,
  input wire logic wakePin,
  output logic sleeping,
  // Core state
  output logic [15:0] pcOut,
  output logic [7:0] ccrOut,
  output logic regWrite,
  output logic [7:0] regWriteData,
  // Block move registers
  input wire logic [7:0] moveCount,
  input wire logic [15:0] moveSrc,
  input wire logic [15:0] moveDst,
  output logic moveWrite,
  output logic [7:0] moveCountOut,
  output logic [15:0] moveSrcOut,
  output logic [15:0] moveDstOut,
  // Internal bus
  output logic busStrobe,
  output logic [15:0] busAddr,
  output logic busWrite,
  output logic busWord,
  output logic busPeriph,
  output logic [15:0] busWdata,
  input wire logic [15:0] busRdata
);

  localparam int PW = $clog2(STACK_DEPTH);

  typedef enum logic [1:0] {ST_IDLE, ST_MOVE_RD, ST_MOVE_WR, ST_SLEEP} bsbm_state_t;

  bsbm_state_t state_reg;
  logic [15:0] pc_reg;
  logic [7:0] ccr_reg;
  logic [15:0] excPc_reg;
  logic [7:0] excCcr_reg;
  logic [15:0] retStack_reg [STACK_DEPTH];
  logic [PW-1:0] stackPtr_reg;
  logic [7:0] moveCnt_reg;
  logic [15:0] moveSrc_reg;
  logic [15:0] moveDst_reg;
  logic [7:0] moveByte_reg;
  logic busReq_reg;
  logic [15:0] busReqAddr_reg;
  logic busReqWrite_reg;
  logic wakeMeta_reg;
  logic wakeSync_reg;
  logic condTrue;
  logic accept;
  logic excTake;
  logic busDone;
  logic [15:0] busRd;
  logic [15:0] fallPc;
  logic [15:0] branchPc;
  logic [15:0] retTop;
  logic moveLast;
  logic moveFinish;

  assign accept = instValid && instReady && !excEnter;
  assign excTake = excEnter && (state_reg == ST_IDLE || state_reg == ST_SLEEP);
  assign fallPc = pc_reg + INST_STEP;
  assign branchPc = fallPc + {{8{instDisp[7]}}, instDisp};
  assign retTop = retStack_reg[stackPtr_reg - PW'(1)];
  assign moveLast = moveCnt_reg == 8'h01;
  assign moveFinish = state_reg == ST_MOVE_WR && busDone && moveLast;
  assign pcOut = pc_reg;
  assign ccrOut = ccr_reg;
  assign moveCountOut = moveCnt_reg;
  assign moveSrcOut = moveSrc_reg;
  assign moveDstOut = moveDst_reg;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  bsbm_cond_eval u_cond (
    .condition_code_register(ccr_reg),
    .condSel(instCond),
    .condTrue(condTrue)
  );

  bsbm_bus_cycle u_bus (
    .clk(clk),
    .srst(srst),
    .req(busReq_reg),
    .reqAddr(busReqAddr_reg),
    .reqWrite(busReqWrite_reg),
    .reqWord(1'b0),
    .reqWdata({8'h00, moveByte_reg}),
    .done(busDone),
    .rdata(busRd),
    .busStrobe(busStrobe),
    .busAddr(busAddr),
    .busWrite(busWrite),
    .busWord(busWord),
    .busPeriph(busPeriph),
    .busWdata(busWdata),
    .busRdata(busRdata)
  );

  // Wake pin synchroniser
  always_ff @(posedge clk) begin
    if (srst) begin
      wakeMeta_reg <= 1'b0;
      wakeSync_reg <= 1'b0;
    end else begin
      wakeMeta_reg <= wakePin;
      wakeSync_reg <= wakeMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: issue, block move and power-down
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      instReady <= 1'b1;
      sleeping <= 1'b0;
      busReq_reg <= 1'b0;
      busReqAddr_reg <= 16'h0000;
      busReqWrite_reg <= 1'b0;
    end else begin
      busReq_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (accept && instOp == OP_SLEEP) begin
            state_reg <= ST_SLEEP;
            instReady <= 1'b0;
            sleeping <= 1'b1;
          end else if (accept && instOp == OP_MOVE && moveCount != 8'h00) begin
            state_reg <= ST_MOVE_RD;
            instReady <= 1'b0;
            busReq_reg <= 1'b1;
            busReqAddr_reg <= moveSrc;
            busReqWrite_reg <= 1'b0;
          end
        end
        ST_MOVE_RD: begin
          if (busDone) begin
            state_reg <= ST_MOVE_WR;
            busReq_reg <= 1'b1;
            busReqAddr_reg <= moveDst_reg;
            busReqWrite_reg <= 1'b1;
          end
        end
        ST_MOVE_WR: begin
          if (busDone && moveLast) begin
            state_reg <= ST_IDLE;
            instReady <= 1'b1;
          end else if (busDone) begin
            state_reg <= ST_MOVE_RD;
            busReq_reg <= 1'b1;
            busReqAddr_reg <= moveSrc_reg + 16'h0001;
            busReqWrite_reg <= 1'b0;
          end
        end
        ST_SLEEP: begin
          if (wakeSync_reg || excEnter) begin
            state_reg <= ST_IDLE;
            instReady <= 1'b1;
            sleeping <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          instReady <= 1'b1;
          sleeping <= 1'b0;
        end
      endcase
    end
  end

  // Program counter
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_reg <= PC_RESET;
    end else if (excTake) begin
      pc_reg <= excVector;
    end else if (accept) begin
      case (instOp)
        OP_BCC: pc_reg <= condTrue ? branchPc : fallPc;
        OP_ABS_JUMP: pc_reg <= instTarget;
        OP_REL_CALL: pc_reg <= branchPc;
        OP_ABS_CALL: pc_reg <= instTarget;
        OP_RTS: pc_reg <= retTop;
        OP_EXC_RETURN: pc_reg <= excPc_reg;
        OP_MOVE: pc_reg <= (moveCount == 8'h00) ? fallPc : pc_reg;
        default: pc_reg <= fallPc;
      endcase
    end else if (moveFinish) begin
      pc_reg <= fallPc;
    end
  end

  // Condition code register and the exception context
  always_ff @(posedge clk) begin
    if (srst) begin
      ccr_reg <= CCR_RESET;
      excPc_reg <= PC_RESET;
      excCcr_reg <= CCR_RESET;
    end else if (excTake) begin
      excPc_reg <= pc_reg;
      excCcr_reg <= ccr_reg;
    end else if (accept) begin
      case (instOp)
        OP_LOAD_CC_IMM: ccr_reg <= instImm;
        OP_LOAD_CC_REG: ccr_reg <= instRegData;
        OP_AND_CC: ccr_reg <= ccr_reg & instImm;
        OP_OR_CC: ccr_reg <= ccr_reg | instImm;
        OP_XOR_CC: ccr_reg <= ccr_reg ^ instImm;
        OP_EXC_RETURN: ccr_reg <= excCcr_reg;
        default: ccr_reg <= ccr_reg;
      endcase
    end
  end

  // Return address stack pointer
  always_ff @(posedge clk) begin
    if (srst) begin
      stackPtr_reg <= '0;
    end else if (accept && (instOp == OP_REL_CALL || instOp == OP_ABS_CALL)) begin
      stackPtr_reg <= stackPtr_reg + PW'(1);
    end else if (accept && instOp == OP_RTS) begin
      stackPtr_reg <= stackPtr_reg - PW'(1);
    end
  end

  // Return address storage, one entry per slot
  for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
    always_ff @(posedge clk) begin
      if (accept && (instOp == OP_REL_CALL || instOp == OP_ABS_CALL) && stackPtr_reg == PW'(i)) begin
        retStack_reg[i] <= fallPc;
      end
    end
  end

  // General register write-back of the flag byte
  always_ff @(posedge clk) begin
    if (srst) begin
      regWrite <= 1'b0;
      regWriteData <= 8'h00;
    end else begin
      regWrite <= accept && instOp == OP_STORE_CC;
      if (accept && instOp == OP_STORE_CC) begin
        regWriteData <= ccr_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Block move count, pointers and data byte
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      moveCnt_reg <= 8'h00;
      moveSrc_reg <= 16'h0000;
      moveDst_reg <= 16'h0000;
      moveByte_reg <= 8'h00;
    end else if (accept && instOp == OP_MOVE) begin
      moveCnt_reg <= moveCount;
      moveSrc_reg <= moveSrc;
      moveDst_reg <= moveDst;
    end else if (state_reg == ST_MOVE_RD && busDone) begin
      moveByte_reg <= busRd[7:0];
    end else if (state_reg == ST_MOVE_WR && busDone) begin
      moveSrc_reg <= moveSrc_reg + 16'h0001;
      moveDst_reg <= moveDst_reg + 16'h0001;
      moveCnt_reg <= moveCnt_reg - 8'h01;
    end
  end

  // Completion pulses
  always_ff @(posedge clk) begin
    if (srst) begin
      moveWrite <= 1'b0;
      instDone <= 1'b0;
    end else begin
      moveWrite <= moveFinish || (accept && instOp == OP_MOVE && moveCount == 8'h00);
      instDone <= moveFinish || (accept && !(instOp == OP_MOVE && moveCount != 8'h00));
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  branchTaken_a: assert property (@(posedge clk) disable iff (srst)
    accept && instOp == OP_BCC && condTrue |=> pc_reg == $past(branchPc))
    else $error("taken branch did not reach target");
  branchFall_a: assert property (@(posedge clk) disable iff (srst)
    accept && instOp == OP_BCC && !condTrue |=> pc_reg == $past(fallPc))
    else $error("untaken branch did not fall through");
  jumpLoad_a: assert property (@(posedge clk) disable iff (srst)
    accept && instOp == OP_ABS_JUMP |=> pc_reg == $past(instTarget))
    else $error("jump target not loaded");
  callReturn_a: assert property (@(posedge clk) disable iff (srst)
    accept && (instOp == OP_REL_CALL || instOp == OP_ABS_CALL) ##1 !accept ##1 accept && instOp == OP_RTS
    |=> pc_reg == $past(fallPc, 3))
    else $error("return did not resume after call");
  excReturn_a: assert property (@(posedge clk) disable iff (srst)
    accept && instOp == OP_EXC_RETURN |=> pc_reg == $past(excPc_reg) && ccr_reg == $past(excCcr_reg))
    else $error("exception return lost context");
  sleepEntry_a: assert property (@(posedge clk) disable iff (srst)
    accept && instOp == OP_SLEEP |=> sleeping && !instReady)
    else $error("sleep not entered");
  ccrAnd_a: assert property (@(posedge clk) disable iff (srst)
    accept && instOp == OP_AND_CC |=> ccr_reg == ($past(ccr_reg) & $past(instImm)))
    else $error("flag AND wrong");
  noOp_a: assert property (@(posedge clk) disable iff (srst)
    accept && instOp == OP_NO_OP |=> pc_reg == $past(pc_reg) + INST_STEP && $stable(ccr_reg))
    else $error("no-operation changed state");
  moveZero_a: assert property (@(posedge clk) disable iff (srst)
    accept && instOp == OP_MOVE && moveCount == 8'h00 |=> moveWrite && instReady && state_reg == ST_IDLE)
    else $error("zero-count move did something");
  moveHold_a: assert property (@(posedge clk) disable iff (srst)
    state_reg == ST_MOVE_RD || state_reg == ST_MOVE_WR |-> !instReady && !instDone)
    else $error("issue open during block move");
  moveRun_c: cover property (@(posedge clk) disable iff (srst) moveFinish && $past(moveCnt_reg) == 8'h01);
  branch_c: cover property (@(posedge clk) disable iff (srst) accept && instOp == OP_BCC && condTrue);
  wake_c: cover property (@(posedge clk) disable iff (srst) state_reg == ST_SLEEP ##1 state_reg == ST_IDLE);

endmodule : bsbm_exec

`default_nettype wire

// File: hdl/bsbm_pkg.sv
// Shared constants and types for the branch, system control and block-move execution unit
`default_nettype none

package bsbm_pkg;

  // ----------------------------------------------------------------
  // Reset values and program counter stepping
  // ----------------------------------------------------------------
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] CCR_RESET = 8'h00;
  localparam logic [15:0] INST_STEP = 16'h0002;

  // ----------------------------------------------------------------
  // Condition code register field positions
  // ----------------------------------------------------------------
  localparam int CCR_C = 0;
  localparam int CCR_V = 1;
  localparam int CCR_Z = 2;
  localparam int CCR_N = 3;

  // ----------------------------------------------------------------
  // Branch condition selector codes
  // ----------------------------------------------------------------
  localparam logic [3:0] COND_ALWAYS = 4'h0;
  localparam logic [3:0] COND_NEVER = 4'h1;
  localparam logic [3:0] COND_HIGHER = 4'h2;
  localparam logic [3:0] COND_LOW_SAME = 4'h3;
  localparam logic [3:0] COND_CARRY_CLR = 4'h4;
  localparam logic [3:0] COND_CARRY_SET = 4'h5;
  localparam logic [3:0] COND_NOT_EQUAL = 4'h6;
  localparam logic [3:0] COND_EQUAL = 4'h7;
  localparam logic [3:0] COND_OVF_CLR = 4'h8;
  localparam logic [3:0] COND_OVF_SET = 4'h9;
  localparam logic [3:0] COND_PLUS = 4'ha;
  localparam logic [3:0] COND_MINUS = 4'hb;
  localparam logic [3:0] COND_GE = 4'hc;
  localparam logic [3:0] COND_LT = 4'hd;
  localparam logic [3:0] COND_GT = 4'he;
  localparam logic [3:0] COND_LE = 4'hf;

  // ----------------------------------------------------------------
  // Address decode and bus cycle lengths in states
  // ----------------------------------------------------------------
  localparam logic [15:0] PERIPH_BASE = 16'hff80;
  localparam logic [15:0] SLOW_LOW = 16'hffa8;
  localparam logic [15:0] SLOW_HIGH = 16'hffad;
  localparam logic [1:0] MEM_STATES = 2'h2;
  localparam logic [1:0] PERIPH_FAST_STATES = 2'h2;
  localparam logic [1:0] PERIPH_SLOW_STATES = 2'h3;

  // Operations handled by the unit
  typedef enum logic [3:0] {
    OP_NO_OP, OP_BCC, OP_ABS_JUMP, OP_REL_CALL, OP_ABS_CALL, OP_RTS, OP_EXC_RETURN, OP_SLEEP,
    OP_LOAD_CC_IMM, OP_LOAD_CC_REG, OP_STORE_CC, OP_AND_CC, OP_OR_CC, OP_XOR_CC, OP_MOVE
  } bsbm_op_t;

endpackage : bsbm_pkg

`default_nettype wire

// File: hdl/bsbm_cond_eval.sv
// Branch condition evaluation from the condition code register
`default_nettype none

module bsbm_cond_eval
  import bsbm_pkg::*;
(
  // Flags and selector
  input wire logic [7:0] condition_code_register,
  input wire logic [3:0] condSel,
  // Result
  output logic condTrue
);

  logic flagC;
  logic flagV;
  logic flagZ;
  logic flagN;

  assign flagC = condition_code_register[CCR_C];
  assign flagV = condition_code_register[CCR_V];
  assign flagZ = condition_code_register[CCR_Z];
  assign flagN = condition_code_register[CCR_N];

  // Selector decode, one term per condition
  always_comb begin
    case (condSel)
      COND_ALWAYS: condTrue = 1'b1;
      COND_NEVER: condTrue = 1'b0;
      COND_HIGHER: condTrue = !(flagC | flagZ);
      COND_LOW_SAME: condTrue = flagC | flagZ;
      COND_CARRY_CLR: condTrue = !flagC;
      COND_CARRY_SET: condTrue = flagC;
      COND_NOT_EQUAL: condTrue = !flagZ;
      COND_EQUAL: condTrue = flagZ;
      COND_OVF_CLR: condTrue = !flagV;
      COND_OVF_SET: condTrue = flagV;
      COND_PLUS: condTrue = !flagN;
      COND_MINUS: condTrue = flagN;
      COND_GE: condTrue = !(flagN ^ flagV);
      COND_LT: condTrue = flagN ^ flagV;
      COND_GT: condTrue = !(flagZ | (flagN ^ flagV));
      COND_LE: condTrue = flagZ | (flagN ^ flagV);
      default: condTrue = 1'b0;
    endcase
  end

endmodule : bsbm_cond_eval

`default_nettype wire

// File: hdl/bsbm_bus_cycle.sv
// Bus cycle sequencer for on-chip memory and peripheral accesses
`default_nettype none

module bsbm_bus_cycle
  import bsbm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Request from the execution unit
  input wire logic req,
  input wire logic [15:0] reqAddr,
  input wire logic reqWrite,
  input wire logic reqWord,
  input wire logic [15:0] reqWdata,
  output logic done,
  output logic [15:0] rdata,
  // Internal bus
  output logic busStrobe,
  output logic [15:0] busAddr,
  output logic busWrite,
  output logic busWord,
  output logic busPeriph,
  output logic [15:0] busWdata,
  input wire logic [15:0] busRdata
);

  logic reqPeriph;
  logic reqSlow;
  logic [1:0] stateCnt_reg;
  logic [1:0] needStates_reg;
  logic slow_reg;

  assign reqPeriph = reqAddr >= PERIPH_BASE;
  assign reqSlow = reqPeriph && reqAddr >= SLOW_LOW && reqAddr <= SLOW_HIGH;

  // ----------------------------------------------------------------
  // Cycle sequencing: one state per clock, two or three states per cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      busStrobe <= 1'b0;
      stateCnt_reg <= 2'h0;
      needStates_reg <= MEM_STATES;
      slow_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (req && !busStrobe) begin
        busStrobe <= 1'b1;
        stateCnt_reg <= 2'h1;
        slow_reg <= reqSlow;
        needStates_reg <= !reqPeriph ? MEM_STATES : (reqSlow ? PERIPH_SLOW_STATES : PERIPH_FAST_STATES);
      end else if (busStrobe) begin
        if (stateCnt_reg == needStates_reg) begin
          busStrobe <= 1'b0;
          done <= 1'b1;
        end else begin
          stateCnt_reg <= stateCnt_reg + 2'h1;
        end
      end
    end
  end

  // Address, lanes and size; peripherals see bytes on the low lane only
  always_ff @(posedge clk) begin
    if (srst) begin
      busAddr <= 16'h0000;
      busWrite <= 1'b0;
      busWord <= 1'b0;
      busPeriph <= 1'b0;
      busWdata <= 16'h0000;
    end else if (req && !busStrobe) begin
      busAddr <= reqAddr;
      busWrite <= reqWrite;
      busPeriph <= reqPeriph;
      busWord <= reqWord && !reqPeriph;
      if (reqPeriph) begin
        busWdata <= {8'h00, reqWdata[7:0]};
      end else if (reqWord) begin
        busWdata <= reqWdata;
      end else begin
        busWdata <= {reqWdata[7:0], reqWdata[7:0]};
      end
    end
  end

  // Read data capture at the end of the last state; byte lane picked by address
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 16'h0000;
    end else if (busStrobe && stateCnt_reg == needStates_reg) begin
      if (busPeriph) begin
        rdata <= {8'h00, busRdata[7:0]};
      end else if (busWord) begin
        rdata <= busRdata;
      end else begin
        rdata <= {8'h00, busAddr[0] ? busRdata[7:0] : busRdata[15:8]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  memTwoState_a: assert property (@(posedge clk) disable iff (srst)
    $rose(busStrobe) && !busPeriph |-> busStrobe[*2] ##1 !busStrobe ##0 done)
    else $error("memory cycle not two states");
  periphSlow_a: assert property (@(posedge clk) disable iff (srst)
    $rose(busStrobe) && busPeriph && slow_reg |-> busStrobe[*3] ##1 !busStrobe)
    else $error("slow peripheral cycle not three states");
  periphByte_a: assert property (@(posedge clk) disable iff (srst)
    busStrobe && busPeriph |-> !busWord && busWdata[15:8] == 8'h00)
    else $error("word access reached a peripheral");
  slowCycle_c: cover property (@(posedge clk) disable iff (srst) $rose(busStrobe) && slow_reg);

endmodule : bsbm_bus_cycle

`default_nettype wire

// File: test/bsbm_mem_model.sv
// Behavioural on-chip memory and peripheral space
`default_nettype none
// ----------------
// Memory model
// ----------------
module bsbm_mem_model (
  // Clock
  input wire logic clk,
  // Bus from the core
  input wire logic busStrobe,
  input wire logic [15:0] busAddr,
  input wire logic busWrite,
  input wire logic [15:0] busWdata,
  // Read data
  output logic [15:0] busRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wmem [256];
  logic [15:0] lastRd = 16'h0000;
  // Store the low lane, which carries the byte for both targets
  always @(posedge clk) begin
    if (busStrobe && busWrite) wmem[busAddr[7:0]] <= busWdata[7:0];
    lastRd <= busRdata;
  end
  // Known byte while read, else a value that keeps changing
  assign busRdata = (busStrobe && !busWrite) ? {2{busAddr[7:0] ^ 8'h5a}} : ~lastRd;
endmodule : bsbm_mem_model
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the branch, system control and block-move unit
`default_nettype none
// ----------------
// Bench top
// ----------------
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bsbm_pkg::*;
  logic clk = 1'b0, srst = 1'b1, instValid = 1'b0, excEnter = 1'b0, wakePin = 1'b0;
  bsbm_op_t instOp = OP_NO_OP;
  logic [3:0] instCond = 4'h0;
  logic [7:0] instDisp = 8'h00, instImm = 8'h00, instRegData = 8'h00, moveCount = 8'h00;
  logic [15:0] instTarget = 16'h0000, excVector = 16'h0000, moveSrc = 16'h0000, moveDst = 16'h0000;
  logic instReady, instDone, sleeping, regWrite, moveWrite, busStrobe, busWrite, busWord, busPeriph, rw, mw;
  logic [7:0] ccrOut, regWriteData, moveCountOut, rwd;
  logic [15:0] pcOut, moveSrcOut, moveDstOut, busAddr, busWdata, busRdata, pc = 16'h0000;
  int mismatches = 0, compares = 0, strobeCyc = 0;
  bsbm_exec dut (.clk, .srst, .instValid, .instOp, .instCond, .instDisp, .instTarget, .instImm,
    .instRegData, .instReady, .instDone, .excEnter, .excVector, .wakePin, .sleeping, .pcOut, .ccrOut,
    .regWrite, .regWriteData, .moveCount, .moveSrc, .moveDst, .moveWrite, .moveCountOut, .moveSrcOut,
    .moveDstOut, .busStrobe, .busAddr, .busWrite, .busWord, .busPeriph, .busWdata, .busRdata);
  bsbm_mem_model mem (.clk, .busStrobe, .busAddr, .busWrite, .busWdata, .busRdata);
  // Clock at 10 MHz
  always #50 clk = ~clk;
  // Count bus states and watch peripheral access width
  always @(negedge clk) begin
    if (busStrobe === 1'b1) strobeCyc++;
    if (busStrobe === 1'b1 && busPeriph === 1'b1) check(16'(busWord), 16'h0000);
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // A wait that used up its bound ends the run
  task automatic bail(input int n, input int lim);
    if (n >= lim) begin
      check(16'h0000, 16'h0001);
      give_verdict();
    end
  endtask : bail
  // Offer one instruction, then wait for its completion pulse
  task automatic issue(input bsbm_op_t op, input logic [7:0] d, input logic [15:0] t, input logic [7:0] i);
    int n;
    n = 0;
    @(negedge clk);
    while (instReady !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    bail(n, 50);
    instValid = 1'b1;
    instOp = op;
    instDisp = d;
    instTarget = t;
    instImm = i;
    @(negedge clk);
    instValid = 1'b0;
    n = 0;
    while (instDone !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    bail(n, 100);
    rw = regWrite;
    rwd = regWriteData;
    mw = moveWrite;
  endtask : issue
  task automatic t_flow();
    issue(OP_NO_OP, 8'h00, 16'h0000, 8'h00);
    check(pcOut, 16'h0002);
    check(16'(ccrOut), 16'h0000);
    issue(OP_ABS_JUMP, 8'h00, 16'h1234, 8'h00);
    check(pcOut, 16'h1234);
    issue(OP_REL_CALL, 8'hf0, 16'h0000, 8'h00);
    check(pcOut, 16'h1226);
    issue(OP_ABS_CALL, 8'h00, 16'h4000, 8'h00);
    check(pcOut, 16'h4000);
    issue(OP_RTS, 8'h00, 16'h0000, 8'h00);
    check(pcOut, 16'h1228);
    issue(OP_RTS, 8'h00, 16'h0000, 8'h00);
    check(pcOut, 16'h1236);
    pc = 16'h1236;
  endtask : t_flow
  // Every condition against four flag patterns, branching back by six
  task automatic t_branch();
    logic [7:0] fl [4] = '{8'h00, 8'h0f, 8'h09, 8'h06};
    logic n, z, v, c;
    logic [15:0] tv;
    for (int k = 0; k < 4; k++) begin
      issue(OP_LOAD_CC_IMM, 8'h00, 16'h0000, fl[k]);
      pc += 16'h0002;
      check(16'(ccrOut), 16'(fl[k]));
      {n, z, v, c} = fl[k][3:0];
      tv = {z | (n ^ v), !(z | (n ^ v)), n ^ v, !(n ^ v), n, !n, v, !v, z, !z, c, !c, c | z, !(c | z), 2'b01};
      for (int s = 0; s < 16; s++) begin
        instCond = 4'(s);
        issue(OP_BCC, 8'hfa, 16'h0000, 8'h00);
        pc = pc + 16'h0002 + (tv[s] ? 16'hfffa : 16'h0000);
        check(pcOut, pc);
      end
    end
  endtask : t_branch
  task automatic t_ccr();
    instRegData = 8'ha5;
    issue(OP_LOAD_CC_REG, 8'h00, 16'h0000, 8'h00);
    check(16'(ccrOut), 16'h00a5);
    issue(OP_AND_CC, 8'h00, 16'h0000, 8'h3c);
    check(16'(ccrOut), 16'h0024);
    issue(OP_OR_CC, 8'h00, 16'h0000, 8'h81);
    check(16'(ccrOut), 16'h00a5);
    issue(OP_XOR_CC, 8'h00, 16'h0000, 8'hff);
    check(16'(ccrOut), 16'h005a);
    issue(OP_STORE_CC, 8'h00, 16'h0000, 8'h00);
    check(16'({rw, rwd}), 16'h015a);
    pc += 16'h000a;
    check(pcOut, pc);
  endtask : t_ccr
  // Block copy of cnt bytes costing per bus states for each byte
  task automatic t_move(input logic [7:0] cnt, input logic [15:0] src, input logic [15:0] dst, input int per);
    int s0;
    s0 = strobeCyc;
    moveCount = cnt;
    moveSrc = src;
    moveDst = dst;
    issue(OP_MOVE, 8'h00, 16'h0000, 8'h00);
    pc += 16'h0002;
    check(pcOut, pc);
    check(16'(moveCountOut), 16'h0000);
    check(16'(mw), 16'h0001);
    check(moveSrcOut, src + 16'(cnt));
    check(moveDstOut, dst + 16'(cnt));
    check(16'(strobeCyc - s0), 16'(per * cnt));
    for (int k = 0; k < cnt; k++) check(16'(mem.wmem[8'(dst + 16'(k))]), 16'(8'(src + 16'(k)) ^ 8'h5a));
  endtask : t_move
  task automatic t_exc();
    issue(OP_LOAD_CC_IMM, 8'h00, 16'h0000, 8'h03);
    pc += 16'h0002;
    @(negedge clk);
    excVector = 16'h0200;
    excEnter = 1'b1;
    @(negedge clk);
    excEnter = 1'b0;
    @(negedge clk);
    check(pcOut, 16'h0200);
    issue(OP_LOAD_CC_IMM, 8'h00, 16'h0000, 8'h00);
    issue(OP_EXC_RETURN, 8'h00, 16'h0000, 8'h00);
    check(pcOut, pc);
    check(16'(ccrOut), 16'h0003);
  endtask : t_exc
  task automatic t_sleep();
    int n;
    @(negedge clk);
    instOp = OP_SLEEP;
    instValid = 1'b1;
    @(negedge clk);
    instValid = 1'b0;
    @(negedge clk);
    pc += 16'h0002;
    check(16'(sleeping), 16'h0001);
    check(pcOut, pc);
    wakePin = 1'b1;
    for (n = 0; n < 10 && sleeping !== 1'b0; n++) @(negedge clk);
    bail(n, 10);
    wakePin = 1'b0;
    check(16'(instReady), 16'h0001);
  endtask : t_sleep
  // Reset, then each scenario in turn
  initial begin
    repeat (5) @(negedge clk);
    srst = 1'b0;
    t_flow();
    t_branch();
    t_ccr();
    t_move(8'h03, 16'h0010, 16'h0100, 4);
    t_move(8'h02, 16'hffa8, 16'h0040, 5);
    t_move(8'h00, 16'hffaa, 16'h0042, 0);
    t_exc();
    t_sleep();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
